// ===== hw/lnk_pkg.sv
package lnk_pkg;

    // link speed settings
    typedef enum logic [1:0] {
        LNK_RATE_20K,
        LNK_RATE_10K,
        LNK_RATE_FAST
    } lnk_rate_e;

    // requested interface mode
    typedef enum logic [1:0] {
        LNK_MODE_DISABLE,
        LNK_MODE_TXRX,
        LNK_MODE_SLEEP
    } lnk_mode_e;

    // settings issued by the serial command decoder
    typedef struct packed {
        logic cmd_valid;
        lnk_mode_e cmd_mode;
        lnk_rate_e cmd_rate;
        logic wake_enable;
    } lnk_cmd_s;

    // analog status indications
    typedef struct packed {
        logic supply_uv;
        logic over_temp;
        logic device_normal;
    } lnk_ana_s;

    localparam int LNK_CLK_HZ = 100_000_000;
    localparam int LNK_WAKE_MIN_US = 70;
    // dominant must last longer than this count to read as a wake-up
    localparam int LNK_WAKE_CYC = (LNK_WAKE_MIN_US * (LNK_CLK_HZ / 1_000_000));
    // dominant timeout: plain default in microseconds, tune per system
    localparam int LNK_TXDOM_US = 20_000;
    localparam int LNK_TXDOM_CYC = LNK_TXDOM_US * (LNK_CLK_HZ / 1_000_000);
    localparam int LNK_CNT_W = 22;

    localparam lnk_mode_e LNK_MODE_RST = LNK_MODE_DISABLE;
    localparam lnk_rate_e LNK_RATE_RST = LNK_RATE_20K;

endpackage

// ===== hw/lnk_wake_det.sv
`timescale 1ns/10ps
module lnk_wake_det
    import lnk_pkg::*;
#(
    parameter int WAKE_CYC = LNK_WAKE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic arm,
    input wire logic bus_level,
    // result
    output logic wake_pulse
);

    typedef enum logic [1:0] {
        LNK_W_IDLE,
        LNK_W_DOM,
        LNK_W_LONG
    } lnk_wst_e;

    typedef struct packed {
        lnk_wst_e st;
        logic [15:0] cnt;
        logic bus_q;
        logic pulse;
    } lnk_wake_s;

    lnk_wake_s cur;
    lnk_wake_s next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.bus_q = bus_level;
        next_cur.pulse = 1'b0;
        if (!arm) begin
            next_cur.st = LNK_W_IDLE;
            next_cur.cnt = 16'h0000;
        end else begin
            case (cur.st)
                LNK_W_IDLE: begin
                    // only a real recessive-to-dominant edge starts a measurement
                    if (cur.bus_q && !bus_level) begin
                        next_cur.st = LNK_W_DOM;
                        next_cur.cnt = 16'h0000;
                    end
                end
                LNK_W_DOM: begin
                    if (bus_level) begin
                        next_cur.st = LNK_W_IDLE;
                    end else if (cur.cnt >= 16'(WAKE_CYC)) begin
                        next_cur.st = LNK_W_LONG;
                    end else begin
                        next_cur.cnt = cur.cnt + 16'h0001;
                    end
                end
                LNK_W_LONG: begin
                    if (bus_level) begin
                        next_cur.st = LNK_W_IDLE;
                        next_cur.pulse = 1'b1;
                    end
                end
                default: next_cur.st = LNK_W_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '{st: LNK_W_IDLE, cnt: 16'h0000, bus_q: 1'b1, pulse: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign wake_pulse = cur.pulse;

endmodule

// ===== hw/lnk_ctrl.sv
// Function
// - supply undervoltage forces the bus recessive, transmit path off
// - interface transmits only while the device is in normal mode
// - host picks 20k, 10k or fast rate; matching slew setting applied
// - overtemperature disables driver and receiver; recovers by itself when cleared
// - transmit-receive mode: input low drives dominant, high releases bus
// - input low past dominant timeout forces recessive and sets status flag
// - receive output mirrors bus level while rx_enable is set: high recessive, low dominant
// - modes: transmit-receive, disabled and sleep, chosen by command
// - transmit-receive command taken only while transmit input is high
// - sleep disables transmission and keeps watching the bus for wake-up
// - sleep uses the high-value pull-up instead of the normal one
// - wake-up needs falling edge, dominant over 70 us, then rising edge
// - detected wake-up is signalled to the device mode machine
// - host can enable or disable bus wake-up detection
`timescale 1ns/10ps
module lnk_ctrl
    import lnk_pkg::*;
#(
    parameter int TXDOM_CYC = LNK_TXDOM_CYC,
    parameter int WAKE_CYC = LNK_WAKE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // settings from the serial command decoder
    input wire lnk_cmd_s cmd,
    // analog indications
    input wire lnk_ana_s ana,
    // host side pins
    input wire logic lin_tx_input_second,
    output logic lin_rx_output_second,
    // bus side
    input wire logic bus_level,
    output logic bus_drive_dom,
    output logic pullup_normal,
    output logic pullup_sleep,
    output logic rx_enable,
    output lnk_rate_e slew_rate,
    // status
    output lnk_mode_e mode,
    output logic tx_dominant_timeout,
    output logic wake_event
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        lnk_mode_e mode;
        lnk_rate_e rate;
        logic wake_en;
        logic [LNK_CNT_W-1:0] dom_cnt;
        logic tx_q;
        logic dom_to;
        logic drive;
        logic rxo;
        logic rx_en;
        logic pu_n;
        logic pu_s;
        logic wake;
    } lnk_ctrl_s;

    lnk_ctrl_s cur;
    lnk_ctrl_s next_cur;
    logic wake_pulse;
    logic wake_arm;

    // detector only armed in sleep with wake-up enabled
    assign wake_arm = (cur.mode == LNK_MODE_SLEEP) && cur.wake_en;

    lnk_wake_det #(
        .WAKE_CYC(WAKE_CYC)
    ) u_wake (
        .clk(clk),
        .rst(rst),
        .arm(wake_arm),
        .bus_level(bus_level),
        .wake_pulse(wake_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_cur = cur;
        next_cur.tx_q = lin_tx_input_second;
        next_cur.wake_en = cmd.wake_enable;
        if (cmd.cmd_valid) begin
            next_cur.rate = cmd.cmd_rate;
            case (cmd.cmd_mode)
                LNK_MODE_TXRX: begin
                    // ignored while the host holds the line dominant
                    if (lin_tx_input_second) begin
                        next_cur.mode = LNK_MODE_TXRX;
                    end
                end
                LNK_MODE_SLEEP: next_cur.mode = LNK_MODE_SLEEP;
                default: next_cur.mode = LNK_MODE_DISABLE;
            endcase
        end
        // dominant timeout; a falling edge restarts, a high input releases
        if (!lin_tx_input_second) begin
            if (cur.tx_q) begin
                next_cur.dom_cnt = '0;
            end else if (cur.dom_cnt >= LNK_CNT_W'(TXDOM_CYC)) begin
                next_cur.dom_to = 1'b1;
            end else begin
                next_cur.dom_cnt = cur.dom_cnt + 1'b1;
            end
        end else begin
            next_cur.dom_cnt = '0;
            next_cur.dom_to = 1'b0;
        end
        next_cur.drive = (cur.mode == LNK_MODE_TXRX) && !lin_tx_input_second
            && !ana.supply_uv
            && ana.device_normal
            && !ana.over_temp
            && !next_cur.dom_to;
        next_cur.rx_en = (cur.mode == LNK_MODE_TXRX) && ana.device_normal
            && !ana.over_temp;
        // receiver off reads as recessive so the host sees an idle bus
        next_cur.rxo = next_cur.rx_en ? bus_level : 1'b1;
        next_cur.pu_s = (cur.mode == LNK_MODE_SLEEP);
        next_cur.pu_n = (cur.mode != LNK_MODE_SLEEP);
        next_cur.wake = wake_pulse;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur <= '{mode: LNK_MODE_RST, rate: LNK_RATE_RST, wake_en: 1'b0,
                dom_cnt: '0, tx_q: 1'b1, dom_to: 1'b0, drive: 1'b0, rxo: 1'b1,
                rx_en: 1'b0, pu_n: 1'b1, pu_s: 1'b0, wake: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign bus_drive_dom = cur.drive;
    assign lin_rx_output_second = cur.rxo;
    assign rx_enable = cur.rx_en;
    assign pullup_normal = cur.pu_n;
    assign pullup_sleep = cur.pu_s;
    assign slew_rate = cur.rate;
    assign mode = cur.mode;
    assign tx_dominant_timeout = cur.dom_to;
    assign wake_event = cur.wake;

endmodule

// ===== testbench/lnk_bus_node.sv
`timescale 1ns/10ps
module lnk_bus_node (
    // local driver and remote nodes
    input wire logic bus_drive_dom,
    input wire logic remote_dom,
    // wire level
    output logic bus_level
);
    // pull-up holds the released wire recessive; any dominant node wins
    assign bus_level = !(bus_drive_dom || remote_dom);
endmodule

// ===== testbench/lnk_ctrl_properties.sv
`timescale 1ns/10ps
module lnk_ctrl_chk
    import lnk_pkg::*;
#(
    parameter int TXDOM_CYC = LNK_TXDOM_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // block inputs
    input wire lnk_cmd_s cmd,
    input wire lnk_ana_s ana,
    input wire logic lin_tx_input_second,
    input wire logic bus_level,
    // block outputs
    input wire logic lin_rx_output_second,
    input wire logic bus_drive_dom,
    input wire logic pullup_normal,
    input wire logic pullup_sleep,
    input wire logic rx_enable,
    input wire lnk_rate_e slew_rate,
    input wire lnk_mode_e mode,
    input wire logic tx_dominant_timeout,
    input wire logic wake_event
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // length of the current low stretch, too long for a repetition count
    logic [31:0] low_cnt;
    always_ff @(posedge clk) begin
        if (rst || lin_tx_input_second) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= low_cnt + 32'h1;
        end
    end
    property p_uv; ana.supply_uv [*2] |-> !bus_drive_dom; endproperty
    a_uv: assert property (p_uv) else $error("drive during undervoltage");
    property p_norm; !ana.device_normal [*2] |-> !bus_drive_dom; endproperty
    a_norm: assert property (p_norm) else $error("drive outside normal");
    property p_rate; cmd.cmd_valid |=> slew_rate == $past(cmd.cmd_rate); endproperty
    a_rate: assert property (p_rate) else $error("rate not taken");
    property p_ot; ana.over_temp [*3] |-> !rx_enable && !bus_drive_dom; endproperty
    a_ot: assert property (p_ot) else $error("active in overtemp");
    property p_rec; lin_tx_input_second [*2] |-> !bus_drive_dom; endproperty
    a_rec: assert property (p_rec) else $error("dominant with tx high");
    property p_rx; (rx_enable && !ana.over_temp) [*2] |->
        lin_rx_output_second == $past(bus_level); endproperty
    a_rx: assert property (p_rx) else $error("rx output off bus");
    property p_ref; cmd.cmd_valid && cmd.cmd_mode == LNK_MODE_TXRX && !lin_tx_input_second
        && mode != LNK_MODE_TXRX |=> mode != LNK_MODE_TXRX; endproperty
    a_ref: assert property (p_ref) else $error("txrx taken with tx low");
    property p_slp; mode == LNK_MODE_SLEEP [*2] |->
        pullup_sleep && !pullup_normal && !bus_drive_dom; endproperty
    a_slp: assert property (p_slp) else $error("sleep pull-up or drive");
    property p_tmo; $rose(tx_dominant_timeout) |-> low_cnt >= TXDOM_CYC; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout flag early");
    property p_rel; lin_tx_input_second |=> !tx_dominant_timeout; endproperty
    a_rel: assert property (p_rel) else $error("timeout flag kept with tx high");
    // a wake pulse needs the detector armed: sleep two edges back, enable three back
    property p_wen; wake_event |->
        $past(cmd.wake_enable, 3) && $past(mode, 2) == LNK_MODE_SLEEP; endproperty
    a_wen: assert property (p_wen) else $error("wake without sleep and enable");
    property p_wpl; wake_event |=> !wake_event; endproperty
    a_wpl: assert property (p_wpl) else $error("wake event longer than a cycle");
endmodule
bind lnk_ctrl lnk_ctrl_chk #(.TXDOM_CYC(TXDOM_CYC)) u_chk (.clk, .rst, .cmd, .ana,
    .lin_tx_input_second, .bus_level, .lin_rx_output_second, .bus_drive_dom, .pullup_normal,
    .pullup_sleep, .rx_enable, .slew_rate, .mode, .tx_dominant_timeout, .wake_event);

// ===== testbench/lnk_ctrl_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module lnk_ctrl_tb_top
    import lnk_pkg::*;
;
    // short counts keep the run brief
    localparam int TXDOM = 50;
    localparam int WAKE = 20;
    logic clk, rst, tx, remote, bus_level, rxo, drive, pu_n, pu_s, rx_en, tmo, wake, exp_rxo;
    lnk_cmd_s cmd;
    lnk_ana_s ana;
    lnk_rate_e slew;
    lnk_mode_e mode;
    int num_errors = 0, comparisons = 0, cyc = 0, wakes = 0;
    lnk_ctrl #(.TXDOM_CYC(TXDOM), .WAKE_CYC(WAKE)) DUT (.clk(clk), .rst(rst), .cmd(cmd),
        .ana(ana), .lin_tx_input_second(tx), .lin_rx_output_second(rxo),
        .bus_level(bus_level), .bus_drive_dom(drive), .pullup_normal(pu_n),
        .pullup_sleep(pu_s), .rx_enable(rx_en), .slew_rate(slew), .mode(mode),
        .tx_dominant_timeout(tmo), .wake_event(wake));
    lnk_bus_node u_bus (.bus_drive_dom(drive), .remote_dom(remote), .bus_level(bus_level));
    function automatic logic exp_drive(logic t, lnk_ana_s a);
        return !t && !a.supply_uv && !a.over_temp && a.device_normal;
    endfunction
    task automatic step(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic send(lnk_mode_e m, lnk_rate_e r);
        @(negedge clk);
        cmd.cmd_valid = 1'b1;
        cmd.cmd_mode = m;
        cmd.cmd_rate = r;
        @(negedge clk);
        cmd.cmd_valid = 1'b0;
    endtask
    task automatic pulse(int n, int exp);
        int w0;
        w0 = wakes;
        remote = 1'b1;
        step(n);
        remote = 1'b0;
        step(6);
        `CHK("wake_event", exp, wakes - w0)
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        wakes <= wakes + int'(wake === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        rst = 1'b1;
        tx = 1'b1;
        remote = 1'b0;
        cmd = '0;
        ana = 3'h1;
        void'($urandom(27036));
        step(10);
        rst = 1'b0;
        `CHK("mode", LNK_MODE_RST, mode)
        `CHK("rx_out", 1'b1, rxo)
        for (int r = 2; r >= 0; r--) begin
            send(LNK_MODE_TXRX, lnk_rate_e'(r));
            `CHK("slew_rate", lnk_rate_e'(r), slew)
            `CHK("mode", LNK_MODE_TXRX, mode)
        end
        send(LNK_MODE_DISABLE, LNK_RATE_FAST);
        tx = 1'b0;
        send(LNK_MODE_TXRX, LNK_RATE_10K);
        `CHK("mode", LNK_MODE_DISABLE, mode)
        `CHK("drive", 1'b0, drive)
        tx = 1'b1;
        send(LNK_MODE_TXRX, lnk_rate_e'($urandom_range(0, 2)));
        step(2);
        repeat (200) begin
            tx = 1'($urandom_range(0, 1));
            remote = 1'($urandom_range(0, 1));
            #1 exp_rxo = bus_level;
            step(1);
            `CHK("drive", exp_drive(tx, ana), drive)
            `CHK("rx_out", exp_rxo, rxo)
        end
        remote = 1'b0;
        tx = 1'b1;
        step(2);
        // undervoltage, overtemperature, leaving normal mode; each recovers alone
        for (int f = 0; f < 3; f++) begin
            ana = lnk_ana_s'(3'h1 ^ (3'h4 >> f));
            tx = 1'b0;
            step(3);
            `CHK("drive", 1'b0, drive)
            if (f == 1) `CHK("rx_enable", 1'b0, rx_en)
            ana = 3'h1;
            step(3);
            `CHK("drive", 1'b1, drive)
            tx = 1'b1;
            step(2);
        end
        tx = 1'b0;
        step(TXDOM - 10);
        tx = 1'b1;
        step(1);
        tx = 1'b0;
        step(TXDOM - 10);
        `CHK("timeout", 1'b0, tmo)
        step(15);
        `CHK("timeout", 1'b1, tmo)
        `CHK("drive", 1'b0, drive)
        tx = 1'b1;
        step(2);
        `CHK("timeout", 1'b0, tmo)
        cmd.wake_enable = 1'b1;
        send(LNK_MODE_SLEEP, LNK_RATE_20K);
        tx = 1'b0;
        step(2);
        `CHK("pullup_sleep", 1'b1, pu_s)
        `CHK("drive", 1'b0, drive)
        tx = 1'b1;
        pulse(WAKE - 5, 0);
        pulse(WAKE + 10, 1);
        cmd.wake_enable = 1'b0;
        step(2);
        pulse(WAKE + 10, 0);
        send(LNK_MODE_TXRX, LNK_RATE_20K);
        step(1);
        `CHK("pullup_normal", 1'b1, pu_n)
        print_verdict();
    end
endmodule
